// ---- verilog/gpc_defines.svh ----
// register offsets, field positions, reset values and counts for the gated counter
`ifndef GPC_DEFINES_SVH
`define GPC_DEFINES_SVH

// register offsets
`define GPC_ADDR_TIMER_CONTROL 8'h00
`define GPC_ADDR_GATE_CONTROL  8'h01
`define GPC_ADDR_COUNT_LOW     8'h02
`define GPC_ADDR_COUNT_HIGH    8'h03
`define GPC_ADDR_IRQ_STATUS    8'h04
`define GPC_ADDR_IRQ_CLEAR     8'h05
`define GPC_ADDR_IRQ_ENABLE    8'h06

// timer_control fields
`define GPC_TC_ON_BIT          0
`define GPC_TC_SYNC_BYPASS_BIT 2
`define GPC_TC_PS_LSB          4
`define GPC_TC_PS_MSB          5
`define GPC_TC_EXT_SRC_BIT     6
`define GPC_TC_MASK            8'h0075

// gate_control fields
`define GPC_GC_SRC_LSB         0
`define GPC_GC_SRC_MSB         1
`define GPC_GC_POL_BIT         6
`define GPC_GC_ON_BIT          7
`define GPC_GC_MASK            8'h00C3

// interrupt status fields
`define GPC_IRQ_WRAP_BIT       0
`define GPC_IRQ_MASK           8'h0001

// reset values and counts
`define GPC_RST_BYTE           8'h00
`define GPC_RST_COUNT          16'h0000
`define GPC_COUNT_MAX          16'hFFFF
`define GPC_COUNT_ONE          16'h0001
`define GPC_PS_RST             3'h0
`define GPC_PS_ONE             3'h1

`endif

// ---- verilog/gpc_pkg.sv ----
// types shared by the gated counter files
package gpc_pkg;

    typedef enum logic [1:0] {
        GPC_GATE_PIN    = 2'h0,
        GPC_GATE_WRAP   = 2'h1,
        GPC_GATE_CMP    = 2'h2,
        GPC_GATE_RESVD  = 2'h3
    } gpc_gate_src_t;

    typedef enum logic [1:0] {
        GPC_DIV_1 = 2'h0,
        GPC_DIV_2 = 2'h1,
        GPC_DIV_4 = 2'h2,
        GPC_DIV_8 = 2'h3
    } gpc_div_t;

endpackage : gpc_pkg

// ---- verilog/gpc_sync2.sv ----
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module gpc_sync2 (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // level
    input  wire logic i_async,
    output logic      o_sync
);

    logic meta_ff;
    logic sync_ff;
    logic nxt_meta;
    logic nxt_sync;

    always_comb begin
        nxt_meta = i_async;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign o_sync = sync_ff;

endmodule : gpc_sync2

// ---- verilog/gpc_prescaler.sv ----
// prescale counter: passes one of every 1, 2, 4 or 8 input ticks
`timescale 1ns/1ps
`include "gpc_defines.svh"
module gpc_prescaler
    import gpc_pkg::*;
(
    // clock and reset
    input  wire logic     i_clk,
    input  wire logic     i_rst_n,
    // control
    input  wire gpc_div_t i_div,
    input  wire logic     i_clear,
    // ticks
    input  wire logic     i_tick,
    output logic          o_tick
);

    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic [2:0] last_cnt;

    // terminal count for the chosen division
    always_comb begin
        case (i_div)
            GPC_DIV_1: last_cnt = 3'h0;
            GPC_DIV_2: last_cnt = 3'h1;
            GPC_DIV_4: last_cnt = 3'h3;
            GPC_DIV_8: last_cnt = 3'h7;
            default:   last_cnt = 3'h0;
        endcase
    end

    assign o_tick = i_tick && !i_clear && (cnt_ff == last_cnt);

    always_comb begin
        nxt_cnt = cnt_ff;
        if (i_clear) begin
            nxt_cnt = `GPC_PS_RST;
        end else if (o_tick) begin
            nxt_cnt = `GPC_PS_RST;
        end else if (i_tick) begin
            nxt_cnt = cnt_ff + `GPC_PS_ONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_ff <= `GPC_PS_RST;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    property p_tick_at_terminal;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_tick |-> (cnt_ff == last_cnt) && i_tick;
    endproperty
    a_tick_at_terminal: assert property (p_tick_at_terminal) else $error("prescaler tick off terminal");

    property p_div8_needs_eight;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_div == GPC_DIV_8) && o_tick && !i_clear |=> (cnt_ff == 3'h0);
    endproperty
    a_div8_needs_eight: assert property (p_div8_needs_eight) else $error("prescaler not restarted");

    property p_clear_zeroes;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_clear |=> (cnt_ff == 3'h0) && !$past(o_tick);
    endproperty
    a_clear_zeroes: assert property (p_clear_zeroes) else $error("prescaler not cleared by write");

endmodule : gpc_prescaler

// ---- verilog/gpc_top.sv ----
// gated prescaled 16-bit counter with register port and wrap interrupt
`timescale 1ns/1ps
`include "gpc_defines.svh"
module gpc_top
    import gpc_pkg::*;
(
    // clock and reset
    input  wire logic       I_MCLK,
    input  wire logic       I_RST_N,
    // register port
    input  wire logic [7:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic      [7:0] O_RDATA,
    // timing and power
    input  wire logic       I_PHASE_TICK,
    input  wire logic       I_SLEEP,
    // clock and gate sources
    input  wire logic       I_EXT_CLK,
    input  wire logic       I_GATE_PIN,
    input  wire logic       I_COMPANION_WRAP,
    input  wire logic       I_CMP_SYNC_OUT,
    // events
    output logic            O_IRQ,
    output logic            O_WAKE
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detect

    logic ext_sync;
    logic gate_pin_sync;
    logic ext_prev_ff;
    logic nxt_ext_prev;
    logic ext_rise;

    gpc_sync2 u_sync_ext (
        .i_clk   (I_MCLK),
        .i_rst_n (I_RST_N),
        .i_async (I_EXT_CLK),
        .o_sync  (ext_sync)
    );

    gpc_sync2 u_sync_gate (
        .i_clk   (I_MCLK),
        .i_rst_n (I_RST_N),
        .i_async (I_GATE_PIN),
        .o_sync  (gate_pin_sync)
    );

    always_comb begin
        nxt_ext_prev = ext_sync;
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            ext_prev_ff <= 1'b0;
        end else begin
            ext_prev_ff <= nxt_ext_prev;
        end
    end

    assign ext_rise = ext_sync && !ext_prev_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0]  tctrl_ff;
    logic [7:0]  gctrl_ff;
    logic [7:0]  irq_en_ff;
    logic [7:0]  irq_stat_ff;
    logic [15:0] count_ff;
    logic [7:0]  rdata_ff;
    logic        pend_ff;
    logic [7:0]  nxt_tctrl;
    logic [7:0]  nxt_gctrl;
    logic [7:0]  nxt_irq_en;
    logic [7:0]  nxt_irq_stat;
    logic [15:0] nxt_count;
    logic [7:0]  nxt_rdata;
    logic        nxt_pend;

    logic          wr_low;
    logic          wr_high;
    logic          wr_count;
    logic          counter_on;
    logic          sync_bypass;
    logic          ext_source;
    gpc_div_t      prescale_select;
    logic          gate_mode_on;
    logic          gate_polarity;
    gpc_gate_src_t gate_source_select;

    assign wr_low             = I_WR && (I_ADDR == `GPC_ADDR_COUNT_LOW);
    assign wr_high            = I_WR && (I_ADDR == `GPC_ADDR_COUNT_HIGH);
    assign wr_count           = wr_low || wr_high;
    assign counter_on         = tctrl_ff[`GPC_TC_ON_BIT];
    assign sync_bypass        = tctrl_ff[`GPC_TC_SYNC_BYPASS_BIT];
    assign ext_source         = tctrl_ff[`GPC_TC_EXT_SRC_BIT];
    assign prescale_select    = gpc_div_t'(tctrl_ff[`GPC_TC_PS_MSB:`GPC_TC_PS_LSB]);
    assign gate_mode_on       = gctrl_ff[`GPC_GC_ON_BIT];
    assign gate_polarity      = gctrl_ff[`GPC_GC_POL_BIT];
    assign gate_source_select = gpc_gate_src_t'(gctrl_ff[`GPC_GC_SRC_MSB:`GPC_GC_SRC_LSB]);

    ////////////////////////////////////////////////////////////////////////////////
    // gate selection

    logic gate_level;
    logic gate_valid;
    logic gate_open;
    logic count_en;

    always_comb begin
        gate_level = 1'b0;
        gate_valid = 1'b1;
        case (gate_source_select)
            GPC_GATE_PIN:  gate_level = gate_pin_sync;
            GPC_GATE_WRAP: gate_level = I_COMPANION_WRAP;
            GPC_GATE_CMP:  gate_level = I_CMP_SYNC_OUT;
            default:       gate_valid = 1'b0;
        endcase
    end

    // one polarity compare shared by all sources
    assign gate_open = gate_valid && (gate_level == gate_polarity);
    assign count_en  = counter_on && (!gate_mode_on || gate_open);

    ////////////////////////////////////////////////////////////////////////////////
    // count clock source

    logic raw_tick;
    logic ps_tick;
    logic inc;

    always_comb begin
        nxt_pend = pend_ff;
        raw_tick = 1'b0;
        if (!ext_source) begin
            raw_tick = I_PHASE_TICK && !I_SLEEP;
            nxt_pend = 1'b0;
        end else if (sync_bypass) begin
            raw_tick = ext_rise;
            nxt_pend = 1'b0;
        end else begin
            // edge waits for the next phase tick, which stops in sleep
            raw_tick = (pend_ff || ext_rise) && I_PHASE_TICK && !I_SLEEP;
            if (raw_tick) begin
                nxt_pend = 1'b0;
            end else if (ext_rise) begin
                nxt_pend = 1'b1;
            end
        end
    end

    gpc_prescaler u_presc (
        .i_clk   (I_MCLK),
        .i_rst_n (I_RST_N),
        .i_div   (prescale_select),
        .i_clear (wr_count),
        .i_tick  (raw_tick && count_en),
        .o_tick  (ps_tick)
    );

    assign inc = ps_tick;

    ////////////////////////////////////////////////////////////////////////////////
    // register next state

    logic wrap;

    assign wrap = inc && !wr_count && (count_ff == `GPC_COUNT_MAX);

    always_comb begin
        nxt_tctrl    = tctrl_ff;
        nxt_gctrl    = gctrl_ff;
        nxt_irq_en   = irq_en_ff;
        nxt_irq_stat = irq_stat_ff;
        nxt_count    = count_ff;
        nxt_rdata    = `GPC_RST_BYTE;
        if (wr_low) begin
            nxt_count[7:0] = I_WDATA;
        end else if (wr_high) begin
            nxt_count[15:8] = I_WDATA;
        end else if (inc) begin
            nxt_count = count_ff + `GPC_COUNT_ONE;
        end
        if (I_WR) begin
            case (I_ADDR)
                `GPC_ADDR_TIMER_CONTROL: nxt_tctrl  = I_WDATA & `GPC_TC_MASK;
                `GPC_ADDR_GATE_CONTROL:  nxt_gctrl  = I_WDATA & `GPC_GC_MASK;
                `GPC_ADDR_IRQ_ENABLE:    nxt_irq_en = I_WDATA & `GPC_IRQ_MASK;
                `GPC_ADDR_IRQ_CLEAR:     nxt_irq_stat = irq_stat_ff & ~(I_WDATA & `GPC_IRQ_MASK);
                default:                 nxt_tctrl  = tctrl_ff;
            endcase
        end
        // set after clear so a same-cycle wrap is kept
        if (wrap) begin
            nxt_irq_stat[`GPC_IRQ_WRAP_BIT] = 1'b1;
        end
        // prescale counter has no address; unmapped reads give zero
        if (I_RD) begin
            case (I_ADDR)
                `GPC_ADDR_TIMER_CONTROL: nxt_rdata = tctrl_ff;
                `GPC_ADDR_GATE_CONTROL:  nxt_rdata = gctrl_ff;
                `GPC_ADDR_COUNT_LOW:     nxt_rdata = count_ff[7:0];
                `GPC_ADDR_COUNT_HIGH:    nxt_rdata = count_ff[15:8];
                `GPC_ADDR_IRQ_STATUS:    nxt_rdata = irq_stat_ff;
                `GPC_ADDR_IRQ_ENABLE:    nxt_rdata = irq_en_ff;
                default:                 nxt_rdata = `GPC_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            tctrl_ff    <= `GPC_RST_BYTE;
            gctrl_ff    <= `GPC_RST_BYTE;
            irq_en_ff   <= `GPC_RST_BYTE;
            irq_stat_ff <= `GPC_RST_BYTE;
            count_ff    <= `GPC_RST_COUNT;
            rdata_ff    <= `GPC_RST_BYTE;
            pend_ff     <= 1'b0;
        end else begin
            tctrl_ff    <= nxt_tctrl;
            gctrl_ff    <= nxt_gctrl;
            irq_en_ff   <= nxt_irq_en;
            irq_stat_ff <= nxt_irq_stat;
            count_ff    <= nxt_count;
            rdata_ff    <= nxt_rdata;
            pend_ff     <= nxt_pend;
        end
    end

    assign O_RDATA = rdata_ff;
    assign O_IRQ   = |(irq_stat_ff & irq_en_ff);
    assign O_WAKE  = I_SLEEP && O_IRQ;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    property p_hold_when_idle;
        @(posedge I_MCLK) disable iff (!I_RST_N)
        !inc && !wr_count |=> (count_ff == $past(count_ff));
    endproperty
    a_hold_when_idle: assert property (p_hold_when_idle) else $error("count moved without tick");

    property p_step_by_one;
        @(posedge I_MCLK) disable iff (!I_RST_N)
        inc && !wr_count |=> (count_ff == 16'($past(count_ff) + 16'h0001));
    endproperty
    a_step_by_one: assert property (p_step_by_one) else $error("count did not step by one");

    sequence s_wrap_tick;
        inc && !wr_count && (count_ff == `GPC_COUNT_MAX);
    endsequence

    sequence s_wrap_seen;
        (count_ff == `GPC_RST_COUNT) && irq_stat_ff[`GPC_IRQ_WRAP_BIT];
    endsequence

    property p_wrap_flag;
        @(posedge I_MCLK) disable iff (!I_RST_N)
        s_wrap_tick |=> s_wrap_seen;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag");

    property p_reserved_gate;
        @(posedge I_MCLK) disable iff (!I_RST_N)
        gate_mode_on && (gate_source_select == GPC_GATE_RESVD) && !wr_count
            |=> (count_ff == $past(count_ff));
    endproperty
    a_reserved_gate: assert property (p_reserved_gate) else $error("reserved gate source counted");

    property p_gate_polarity;
        @(posedge I_MCLK) disable iff (!I_RST_N)
        counter_on && gate_mode_on && (gate_source_select != GPC_GATE_RESVD)
            |-> (count_en == (gate_level == gate_polarity));
    endproperty
    a_gate_polarity: assert property (p_gate_polarity) else $error("gate polarity mismatch");

    property p_free_run;
        @(posedge I_MCLK) disable iff (!I_RST_N)
        counter_on && !gate_mode_on |-> count_en;
    endproperty
    a_free_run: assert property (p_free_run) else $error("free run blocked");

    property p_async_in_sleep;
        @(posedge I_MCLK) disable iff (!I_RST_N)
        I_SLEEP && ext_source && sync_bypass && ext_rise |-> raw_tick;
    endproperty
    a_async_in_sleep: assert property (p_async_in_sleep) else $error("async count stopped in sleep");

    property p_sync_aligned;
        @(posedge I_MCLK) disable iff (!I_RST_N)
        ext_source && !sync_bypass && raw_tick |-> I_PHASE_TICK && !I_SLEEP;
    endproperty
    a_sync_aligned: assert property (p_sync_aligned) else $error("sync count off phase tick");

    property p_read_low;
        @(posedge I_MCLK) disable iff (!I_RST_N)
        I_RD && (I_ADDR == `GPC_ADDR_COUNT_LOW) |=> (O_RDATA == $past(count_ff[7:0]));
    endproperty
    a_read_low: assert property (p_read_low) else $error("low byte read wrong");

    property p_irq_level;
        @(posedge I_MCLK) disable iff (!I_RST_N)
        irq_stat_ff[0] && irq_en_ff[0] |-> O_IRQ;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

endmodule : gpc_top

// ---- tb/gpc_partner.sv ----
// far-side model: external count clock, gate pin, companion wrap, comparator
`timescale 1ns/1ps
module gpc_partner (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // commands from the bench
    input  wire logic i_ext_run,
    input  wire logic i_gate_lvl,
    input  wire logic i_wrap_lvl,
    input  wire logic i_cmp_lvl,
    // far-side pins
    output logic      o_ext_clk,
    output logic      o_gate_pin,
    output logic      o_comp_wrap,
    output logic      o_cmp_out
);
    logic [1:0] half_ff;

    ////////////////////////////////////////////////////////////////////////////
    // external clock: toggles every 3 cycles in a burst, stands low outside
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !i_ext_run) begin
            half_ff   <= 2'h0;
            o_ext_clk <= 1'b0;
        end else if (half_ff == 2'h2) begin
            half_ff   <= 2'h0;
            o_ext_clk <= ~o_ext_clk;
        end else begin
            half_ff <= half_ff + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gate sources as levels
    assign o_gate_pin  = i_gate_lvl;
    assign o_comp_wrap = i_wrap_lvl;
    assign o_cmp_out   = i_cmp_lvl;
endmodule : gpc_partner

// ---- tb/gpc_top_test.sv ----
// self-checking bench for the gated prescaled counter
`timescale 1ns/1ps
`include "gpc_defines.svh"
module gpc_top_test;
    logic       mclk, rst_n, wr, rd, tick, sleep, ext_run, gate_lvl, wrap_lvl, cmp_lvl;
    logic [7:0] addr, wdata, rdata, b;
    logic       ext_clk, gate_pin, comp_wrap, cmp_out, irq, wake;
    int         error_cnt, checks_done, n;

    gpc_top gpc_top_i (.I_MCLK(mclk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .O_RDATA(rdata), .I_PHASE_TICK(tick), .I_SLEEP(sleep), .I_EXT_CLK(ext_clk),
        .I_GATE_PIN(gate_pin), .I_COMPANION_WRAP(comp_wrap), .I_CMP_SYNC_OUT(cmp_out), .O_IRQ(irq),
        .O_WAKE(wake));
    gpc_partner gpc_partner_i (.i_clk(mclk), .i_rst_n(rst_n), .i_ext_run(ext_run), .i_gate_lvl(gate_lvl),
        .i_wrap_lvl(wrap_lvl), .i_cmp_lvl(cmp_lvl), .o_ext_clk(ext_clk), .o_gate_pin(gate_pin),
        .o_comp_wrap(comp_wrap), .o_cmp_out(cmp_out));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare, verdict, expectations
    task automatic cmp_val(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_val

    task automatic cmp_bit(input logic e_irq, input logic e_wake);
        @(negedge mclk);
        cmp_val({15'h0000, irq}, {15'h0000, e_irq});
        cmp_val({15'h0000, wake}, {15'h0000, e_wake});
        @(posedge mclk);
    endtask : cmp_bit

    task automatic conclude();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    function automatic logic [15:0] exp_gate(input int s, input int p, input int l);
        return (s != 3 && p == l) ? 16'h0004 : 16'h0000;
    endfunction : exp_gate

    ////////////////////////////////////////////////////////////////////////////
    // register port and stimulus tasks
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        d = rdata;
        @(posedge mclk);
    endtask : rd_reg

    task automatic tc(input logic on, input logic byp, input logic [1:0] ps, input logic ext);
        wr_reg(`GPC_ADDR_TIMER_CONTROL, {1'b0, ext, ps, 1'b0, byp, 1'b0, on});
    endtask : tc

    task automatic set_count(input logic [15:0] v);
        wr_reg(`GPC_ADDR_COUNT_LOW, v[7:0]);
        wr_reg(`GPC_ADDR_COUNT_HIGH, v[15:8]);
    endtask : set_count

    task automatic chk_count(input logic [15:0] e);
        logic [7:0] lo;
        logic [7:0] hi;
        rd_reg(`GPC_ADDR_COUNT_LOW, lo);
        rd_reg(`GPC_ADDR_COUNT_HIGH, hi);
        cmp_val({hi, lo}, e);
    endtask : chk_count

    task automatic pulse(input int k);
        tick <= 1'b1;
        repeat (k) @(posedge mclk);
        tick <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : pulse

    task automatic ext_edges(input int k);
        ext_run <= 1'b1;
        repeat (6 * k) @(posedge mclk);
        ext_run <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : ext_edges

    ////////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(32'he842_6ac7));
        {rst_n, wr, rd, tick, sleep, ext_run, gate_lvl, wrap_lvl, cmp_lvl} = 9'h000;
        addr = 8'h00;
        wdata = 8'h00;
        error_cnt = 0;
        checks_done = 0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        wr_reg(8'h07, 8'hff);
        for (int a = 0; a < 8; a++) begin
            rd_reg(a[7:0], b);
            cmp_val({8'h00, b}, 16'h0000);
        end
        wr_reg(`GPC_ADDR_TIMER_CONTROL, 8'hff);
        wr_reg(`GPC_ADDR_GATE_CONTROL, 8'hff);
        rd_reg(`GPC_ADDR_TIMER_CONTROL, b);
        cmp_val({8'h00, b}, 16'h0075);
        rd_reg(`GPC_ADDR_GATE_CONTROL, b);
        cmp_val({8'h00, b}, 16'h00c3);
        wr_reg(`GPC_ADDR_GATE_CONTROL, 8'h00);
        // prescale ratios, random tick counts
        for (int d = 0; d < 4; d++) begin
            n = $urandom_range(40, 1);
            tc(1'b1, 1'b0, d[1:0], 1'b0);
            set_count(16'h0000);
            pulse(n);
            chk_count(16'(n >> d));
        end
        // count write clears the prescaler
        tc(1'b1, 1'b0, 2'h3, 1'b0);
        set_count(16'h0000);
        pulse(5);
        wr_reg(`GPC_ADDR_COUNT_LOW, 8'h00);
        pulse(7);
        chk_count(16'h0000);
        pulse(1);
        chk_count(16'h0001);
        tc(1'b0, 1'b0, 2'h0, 1'b0);
        pulse(3);
        chk_count(16'h0001);
        // gate sources and polarity
        tc(1'b1, 1'b0, 2'h0, 1'b0);
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                for (int l = 0; l < 2; l++) begin
                    gate_lvl <= (s == 0 || s == 3) ? l[0] : ~l[0];
                    wrap_lvl <= (s == 1 || s == 3) ? l[0] : ~l[0];
                    cmp_lvl  <= (s == 2 || s == 3) ? l[0] : ~l[0];
                    wr_reg(`GPC_ADDR_GATE_CONTROL, {1'b1, p[0], 4'h0, s[1:0]});
                    set_count(16'h0000);
                    repeat (4) @(posedge mclk);
                    pulse(4);
                    chk_count(exp_gate(s, p, l));
                end
            end
        end
        wr_reg(`GPC_ADDR_GATE_CONTROL, 8'h00);
        // wrap, interrupt mask and clear
        wr_reg(`GPC_ADDR_IRQ_ENABLE, 8'h01);
        set_count(16'hffff);
        pulse(1);
        chk_count(16'h0000);
        rd_reg(`GPC_ADDR_IRQ_STATUS, b);
        cmp_val({8'h00, b}, 16'h0001);
        cmp_bit(1'b1, 1'b0);
        wr_reg(`GPC_ADDR_IRQ_ENABLE, 8'h00);
        cmp_bit(1'b0, 1'b0);
        wr_reg(`GPC_ADDR_IRQ_ENABLE, 8'h01);
        wr_reg(`GPC_ADDR_IRQ_CLEAR, 8'h01);
        cmp_bit(1'b0, 1'b0);
        rd_reg(`GPC_ADDR_IRQ_STATUS, b);
        cmp_val({8'h00, b}, 16'h0000);
        // asynchronous external counting in sleep wakes on wrap
        tc(1'b1, 1'b1, 2'h0, 1'b1);
        set_count(16'hfffe);
        sleep <= 1'b1;
        ext_edges(2);
        cmp_bit(1'b1, 1'b1);
        chk_count(16'h0000);
        sleep <= 1'b0;
        wr_reg(`GPC_ADDR_IRQ_CLEAR, 8'h01);
        // synchronised external edge waits for a phase tick
        tc(1'b1, 1'b0, 2'h0, 1'b1);
        set_count(16'h0000);
        ext_edges(1);
        chk_count(16'h0000);
        pulse(1);
        chk_count(16'h0001);
        conclude();
    end
endmodule : gpc_top_test
